/* dv/pscr_cfg_src.sv */
// Config byte source standing in for the nonvolatile load path
`timescale 1ns/1ns
`default_nettype none
module pscr_cfg_src (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] val,
  output logic            cfg_load,
  output logic [7:0]      cfg_load_data
);
  initial begin
    cfg_load = 1'b0;
    cfg_load_data = 8'h00;
  end
  always @(posedge pclk) begin
    cfg_load <= go;
    cfg_load_data <= go ? val : ~cfg_load_data;
  end
endmodule // pscr_cfg_src
`default_nettype wire

/* dv/pscr_top_props.sv */
// Bus and output checks for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.vh"
module pscr_top_props #(
  parameter WAKE_LONG = 4000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pump_clock_select,
  input wire logic [1:0]  watchdog_rate_select,
  input wire logic        fast_clock_output,
  input wire logic [3:0]  area_guard_bits
);
  logic wr_d1;
  logic wr_d2;
  // History of completed writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_d1 <= 1'b0;
      wr_d2 <= 1'b0;
    end else begin
      wr_d1 <= psel && penable && pready && pwrite;
      wr_d2 <= wr_d1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_once; pready |=> !pready; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready longer than one cycle");
  property p_rdy_late; $rose(penable) && psel |=> pready; endproperty
  a_rdy_late: assert property (p_rdy_late) else $error("pready late");
  property p_rdy_cause; pready |-> $past(psel && penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
  property p_no_err; !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("error response seen");
  property p_rd_hi; pready && !pwrite && paddr != `PSCR_OFF_DECODE |-> prdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_rate_wr; $changed(watchdog_rate_select) |-> wr_d1 || wr_d2; endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("rate moved without write");
  property p_pump_wr; $changed(pump_clock_select) |-> wr_d1 || wr_d2; endproperty
  a_pump_wr: assert property (p_pump_wr) else $error("pump clock moved without write");
  property p_fco_wr; $changed(fast_clock_output) |-> wr_d1 || wr_d2; endproperty
  a_fco_wr: assert property (p_fco_wr) else $error("fast clock moved without write");
  property p_guard_wr; $changed(area_guard_bits) |-> wr_d1 || wr_d2; endproperty
  a_guard_wr: assert property (p_guard_wr) else $error("guards moved without write");
  c_wr: cover property (psel && penable && pready && pwrite);
  c_rd: cover property (psel && penable && pready && !pwrite);
  c_guard: cover property ($changed(area_guard_bits));
endmodule // pscr_top_props
bind pscr_top pscr_top_props #(.WAKE_LONG(WAKE_LONG)) pscr_top_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pump_clock_select(pump_clock_select), .watchdog_rate_select(watchdog_rate_select),
  .fast_clock_output(fast_clock_output), .area_guard_bits(area_guard_bits));
`default_nettype wire

/* dv/pscr_top_tb.sv */
// Register bank testbench driving APB transfers
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.vh"
module pscr_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, mode_b_pin, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [7:0]  val, cfg_load_data;
  logic        pready, pslverr, cfg_load, cpu, pcs, ies, cwa, fco, hlt, sbg;
  logic        hreq, wevt;
  localparam integer WL = 20;
  logic [1:0]  rate;
  logic [3:0]  agb;
  integer      bad_count = 0;
  integer      n_tests = 0;
  pscr_top #(.WAKE_LONG(WL)) pscr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_b_pin(mode_b_pin), .halt_req(hreq),
    .wake_evt(wevt), .cfg_load(cfg_load), .cfg_load_data(cfg_load_data),
    .converter_power_up(cpu), .pump_clock_select(pcs), .interrupt_edge_sense(ies),
    .clock_watch_active(cwa), .watchdog_rate_select(rate), .fast_clock_output(fco),
    .halted(hlt), .area_guard_bits(agb), .setup_byte_guard(sbg));
  pscr_cfg_src pscr_cfg_src_inst (.pclk(pclk), .go(go), .val(val), .cfg_load(cfg_load),
    .cfg_load_data(cfg_load_data));
  // 25 MHz clock, E-clock pumps allowed
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer, bounded wait for pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer i;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i = i + 1;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (i >= 20) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task dec(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b1, `PSCR_OFF_DECODE, {16'h0, a});
    rdc(`PSCR_OFF_RESULT, e);
  endtask
  // Halt, then wake, counting edges until halted falls
  task hw(input integer n);
    integer i;
    hreq <= 1'b1;
    @(posedge pclk);
    hreq <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(hlt, 1'b1);
    wevt <= 1'b1;
    @(posedge pclk);
    wevt <= 1'b0;
    i = 0;
    while (hlt === 1'b1 && i < 100) begin
      @(posedge pclk);
      i = i + 1;
    end
    chk(i, n + 2);
  endtask
  task rst(input logic mb);
    presetn <= 1'b0;
    mode_b_pin <= mb;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  // Main sequence: normal mode then special mode
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    presetn = 0; mode_b_pin = 1; go = 0; val = 0; rd = 0;
    hreq = 0;
    wevt = 0;
    rst(1'b1);
    rdc(`PSCR_OFF_GUARD, 8'h1F);
    xfer(1'b1, `PSCR_OFF_GUARD, 8'h00);
    rdc(`PSCR_OFF_GUARD, 8'h00);
    rdc(`PSCR_OFF_REMAP, 8'h01);
    xfer(1'b1, `PSCR_OFF_REMAP, 8'h32);
    xfer(1'b1, `PSCR_OFF_REMAP, 8'h45);
    rdc(`PSCR_OFF_REMAP, 8'h32);
    rdc(`PSCR_OFF_STARTUP, 8'h10);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'hFF);
    rdc(`PSCR_OFF_STARTUP, 8'hFF);
    chk({26'h0, cpu, pcs, ies, cwa, rate}, 8'h3F);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'h00);
    rdc(`PSCR_OFF_STARTUP, 8'h37);
    chk({26'h0, cpu, pcs, ies, cwa, rate}, 8'h0F);
    repeat (70) @(posedge pclk);
    rdc(`PSCR_OFF_STATUS, 8'h03);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'hC8);
    rdc(`PSCR_OFF_STARTUP, 8'hFF);
    xfer(1'b1, `PSCR_OFF_GUARD, 8'h05);
    rdc(`PSCR_OFF_GUARD, 8'h05);
    xfer(1'b1, `PSCR_OFF_GUARD, 8'h00);
    rdc(`PSCR_OFF_GUARD, 8'h05);
    chk({27'h0, sbg, agb}, 8'h05);
    xfer(1'b1, `PSCR_OFF_EXTRA, 8'hFF);
    rdc(`PSCR_OFF_EXTRA, 8'hE0);
    chk(fco, 1'b1);
    xfer(1'b1, `PSCR_OFF_SETUP, 8'h00);
    rdc(`PSCR_OFF_SETUP, 8'hFF);
    dec(16'h2000, 8'h01);
    dec(16'h2060, 8'h00);
    dec(16'h3010, 8'h02);
    dec(16'hBF00, 8'h00);
    dec(16'hFE1F, 8'h0C);
    dec(16'hFE20, 8'h04);
    dec(16'hFE60, 8'h0C);
    dec(16'hFEE0, 8'h04);
    rst(1'b0);
    xfer(1'b1, `PSCR_OFF_REMAP, 8'h11);
    dec(16'h1010, 8'h01);
    dec(16'h1060, 8'h02);
    dec(16'hBF00, 8'h03);
    val <= 8'h21;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    rdc(`PSCR_OFF_SETUP, 8'h21);
    dec(16'h2E00, 8'h0C);
    dec(16'h103F, 8'h09);
    repeat (70) @(posedge pclk);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'h00);
    rdc(`PSCR_OFF_STARTUP, 8'h00);
    chk(cwa, 1'b0);
    rdc(`PSCR_OFF_STATUS, 8'h0B);
    hw(`PSCR_WAKE_SHORT);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'h18);
    rdc(`PSCR_OFF_STARTUP, 8'h18);
    chk(cwa, 1'b1);
    xfer(1'b1, `PSCR_OFF_STARTUP, 8'h10);
    rdc(`PSCR_OFF_STARTUP, 8'h10);
    hw(WL);
    print_verdict;
  end
endmodule // pscr_top_tb
`default_nettype wire

/* hw/pscr_defs.vh */
// Constants for the protected system configuration register bank
//
// Contract
// - Remap register writable once, first 64 cycles
// - Scratch page field gives RAM top digit
// - Control page field gives register block digit
// - Registers hide lowest 96 RAM bytes
// - Priority registers, RAM, boot ROM, EEPROM
// - Startup bits once in 64 cycles, normal; code guards only 8'h37 bits, converter, pump and watch enable stay writable
// - Converter power bit enables converter power
// - Pump clock select chooses E or RC
// - Edge sense bit selects level or falling
// - Wake delay bit selects long start delay
// - Clock watch active while enabled or forced
// - Forced watch holds monitor on until reset
// - Rate field scales watchdog period
// - Fast clock output bit drives pin; low zeros
// - Guard bits clearable only in first 64; special mode clears any time
// - Setting guard bit locks until reset
// - Setup byte guard refuses config program; code only flags area_locked at the config byte, cfg_load still loads
// - Four area guards: 32,64,128,288 bytes
// - EEPROM page and enable from config byte
// - Config byte not changed by register writes
// - Special flag is inverse of mode-B pin
`ifndef PSCR_DEFS_VH
`define PSCR_DEFS_VH

// APB byte offsets
`define PSCR_OFF_REMAP    12'h000
`define PSCR_OFF_STARTUP  12'h004
`define PSCR_OFF_EXTRA    12'h008
`define PSCR_OFF_GUARD    12'h00C
`define PSCR_OFF_STATUS   12'h010
`define PSCR_OFF_SETUP    12'h014
`define PSCR_OFF_DECODE   12'h018
`define PSCR_OFF_RESULT   12'h01C

// Reset values
`define PSCR_RST_REMAP    8'h01
`define PSCR_RST_STARTUP  8'h10
`define PSCR_RST_EXTRA    8'h00
`define PSCR_RST_GUARD    8'h1F
`define PSCR_RST_SETUP    8'hFF

// Startup settings field positions
`define PSCR_B_CONV       7
`define PSCR_B_PSEL       6
`define PSCR_B_IRQS       5
`define PSCR_B_WDLY       4
`define PSCR_B_CWE        3
`define PSCR_B_FCW        2
// Once-writable startup mask (sense, delay, forced, rate)
`define PSCR_STARTUP_PROT 8'h37
`define PSCR_B_FCO        7
`define PSCR_EXTRA_MASK   8'hE0
`define PSCR_GUARD_MASK   8'h1F

// Window and wake timing
`define PSCR_WINDOW_CYC   64
`define PSCR_WAKE_LONG    4000
`define PSCR_WAKE_SHORT   4

// Memory map geometry
`define PSCR_REGBLK_LEN   96
`define PSCR_RAM_LEN      1024
`define PSCR_EE_BASE_LOW  12'hE00
`define PSCR_EE_AREA1     12'hE20
`define PSCR_EE_AREA2     12'hE60
`define PSCR_EE_AREA3     12'hEE0
`define PSCR_CFG_LOW      12'h03F
`define PSCR_BOOT_PAGE    8'hBF

// Decoder answer codes
`define PSCR_SEL_NONE     3'd0
`define PSCR_SEL_REG      3'd1
`define PSCR_SEL_RAM      3'd2
`define PSCR_SEL_BOOT     3'd3
`define PSCR_SEL_EE       3'd4

`endif

/* hw/pscr_map_decode.v */
// Memory map priority decoder for on-chip resources
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.vh"
module pscr_map_decode (
  input  wire [15:0] addr,
  input  wire [3:0]  ram_page,
  input  wire [3:0]  reg_page,
  input  wire [3:0]  ee_page,
  input  wire        ee_enable,
  input  wire        boot_enable,
  input  wire [3:0]  area_guard,
  input  wire        setup_guard,
  output reg  [2:0]  sel,
  output reg         area_locked
);
  reg        hit_reg;
  reg        hit_ram;
  reg        hit_boot;
  reg        hit_ee;
  reg [11:0] low;

  // Hits per resource, then fixed priority
  always @* begin
    low      = addr[11:0];
    hit_reg  = (addr[15:12] == reg_page) && (low < `PSCR_REGBLK_LEN);
    hit_ram  = (addr[15:12] == ram_page) && (low < `PSCR_RAM_LEN);
    hit_boot = boot_enable && (addr[15:8] == `PSCR_BOOT_PAGE);
    hit_ee   = ee_enable && (addr[15:12] == ee_page) && (low >= `PSCR_EE_BASE_LOW);
    if (hit_reg) begin
      sel = `PSCR_SEL_REG;
    end else if (hit_ram) begin
      sel = `PSCR_SEL_RAM;
    end else if (hit_boot) begin
      sel = `PSCR_SEL_BOOT;
    end else if (hit_ee) begin
      sel = `PSCR_SEL_EE;
    end else begin
      sel = `PSCR_SEL_NONE;
    end
    // per-area guard sizes, EEPROM hits only
    area_locked = 1'b0;
    if (sel == `PSCR_SEL_EE) begin
      if (low < `PSCR_EE_AREA1) begin
        area_locked = area_guard[0];
      end else if (low < `PSCR_EE_AREA2) begin
        area_locked = area_guard[1];
      end else if (low < `PSCR_EE_AREA3) begin
        area_locked = area_guard[2];
      end else begin
        area_locked = area_guard[3];
      end
    end
    // config byte guard in register block
    if (hit_reg && (low == `PSCR_CFG_LOW)) begin
      area_locked = setup_guard;
    end
  end
endmodule // pscr_map_decode
`default_nettype wire

/* hw/pscr_top.v */
// Protected system configuration register bank with APB slave
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.vh"
module pscr_top #(
  parameter WAKE_LONG = `PSCR_WAKE_LONG
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        mode_b_pin,
  input  wire        halt_req,
  input  wire        wake_evt,
  input  wire        cfg_load,
  input  wire [7:0]  cfg_load_data,
  output reg         converter_power_up,
  output reg         pump_clock_select,
  output reg         interrupt_edge_sense,
  output reg         clock_watch_active,
  output reg  [1:0]  watchdog_rate_select,
  output reg         fast_clock_output,
  output reg         halted,
  output reg  [3:0]  area_guard_bits,
  output reg         setup_byte_guard
);
  localparam [12:0] WAKE_LONG_C  = WAKE_LONG;
  localparam [12:0] WAKE_SHORT_C = `PSCR_WAKE_SHORT;
  localparam [6:0]  WINDOW_C     = `PSCR_WINDOW_CYC;
  localparam [1:0]  ST_RUN  = 2'd0;
  localparam [1:0]  ST_HALT = 2'd1;
  localparam [1:0]  ST_WAKE = 2'd2;

  reg [7:0]  memory_remap_r;
  reg [7:0]  startup_settings_r;
  reg [7:0]  extra_settings_r;
  reg [7:0]  eeprom_write_guard_r;
  reg [7:0]  setup_latch_r;
  reg [15:0] decode_addr_r;
  reg        remap_done_r;
  reg        startup_done_r;
  reg        special_mode_flag_r;
  reg        strap_taken_r;
  reg [1:0]  strap_cnt_r;
  reg [6:0]  win_cnt_r;
  reg [2:0]  modeb_sync_r;
  reg [1:0]  hstate_r;
  reg [12:0] wake_cnt_r;
  reg [31:0] rdata_nxt;
  wire       window_open;
  wire       wr_acc;
  wire       rd_acc;
  wire [7:0] wbyte;
  wire [2:0] dec_sel;
  wire       dec_locked;

  assign wbyte  = pwdata[7:0];
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite;
  assign window_open = (win_cnt_r < WINDOW_C);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= 7'h00;
    end else if (window_open) begin
      win_cnt_r <= win_cnt_r + 7'h01;
    end
  end

  // Mode-B pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modeb_sync_r <= 3'b111;
    end else begin
      modeb_sync_r <= {modeb_sync_r[1:0], mode_b_pin};
    end
  end

  // special flag caught once synchroniser filled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_mode_flag_r <= 1'b0;
      strap_taken_r       <= 1'b0;
      strap_cnt_r         <= 2'b00;
    end else if (!strap_taken_r) begin
      // Wait out the reset fill of the three flops
      if (strap_cnt_r != 2'b11) begin
        strap_cnt_r <= strap_cnt_r + 2'b01;
      end else if (modeb_sync_r[1] == modeb_sync_r[2]) begin
        special_mode_flag_r <= ~modeb_sync_r[2];
        strap_taken_r       <= 1'b1;
      end
    end
  end

  // Protected register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_remap_r       <= `PSCR_RST_REMAP;
      startup_settings_r   <= `PSCR_RST_STARTUP;
      extra_settings_r     <= `PSCR_RST_EXTRA;
      eeprom_write_guard_r <= `PSCR_RST_GUARD;
      remap_done_r         <= 1'b0;
      startup_done_r       <= 1'b0;
      decode_addr_r        <= 16'h0000;
    end else begin
      if (wr_acc) begin
        case (paddr)
          `PSCR_OFF_REMAP: begin
            if (window_open && !remap_done_r) begin
              memory_remap_r <= wbyte;
              remap_done_r   <= 1'b1;
            end
          end
          `PSCR_OFF_STARTUP: begin
            if (special_mode_flag_r || (window_open && !startup_done_r)) begin
              startup_settings_r <= wbyte;
              startup_done_r     <= 1'b1;
            end else begin
              startup_settings_r <= (wbyte & ~`PSCR_STARTUP_PROT) |
                                    (startup_settings_r & `PSCR_STARTUP_PROT);
            end
          end
          `PSCR_OFF_EXTRA: begin
            extra_settings_r <= wbyte & `PSCR_EXTRA_MASK;
          end
          `PSCR_OFF_GUARD: begin
            // clear only in window, normal modes
            if (special_mode_flag_r || window_open) begin
              eeprom_write_guard_r <= wbyte & `PSCR_GUARD_MASK;
            end else begin
              eeprom_write_guard_r <= (eeprom_write_guard_r | wbyte) & `PSCR_GUARD_MASK;
            end
          end
          `PSCR_OFF_DECODE: begin
            decode_addr_r <= pwdata[15:0];
          end
          default: begin
          end
        endcase
      end
      // forced bit stays set until reset
      if (startup_settings_r[`PSCR_B_FCW]) begin
        startup_settings_r[`PSCR_B_FCW] <= 1'b1;
      end
    end
  end

  // config byte loaded only by programming path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_latch_r <= `PSCR_RST_SETUP;
    end else if (cfg_load) begin
      setup_latch_r <= cfg_load_data;
    end
  end

  // Halt and wake sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate_r   <= ST_RUN;
      wake_cnt_r <= 13'h0000;
    end else begin
      case (hstate_r)
        ST_RUN: begin
          if (halt_req) begin
            hstate_r <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (wake_evt) begin
            hstate_r <= ST_WAKE;
            wake_cnt_r <= startup_settings_r[`PSCR_B_WDLY] ? WAKE_LONG_C - 13'h0001
                                                           : WAKE_SHORT_C - 13'h0001;
          end
        end
        ST_WAKE: begin
          if (wake_cnt_r == 13'h0000) begin
            hstate_r <= ST_RUN;
          end else begin
            wake_cnt_r <= wake_cnt_r - 13'h0001;
          end
        end
        default: begin
          hstate_r <= ST_RUN;
        end
      endcase
    end
  end

  // Resource decoder
  pscr_map_decode u_dec (
    .addr        (decode_addr_r),
    .ram_page    (memory_remap_r[7:4]),
    .reg_page    (memory_remap_r[3:0]),
    .ee_page     (setup_latch_r[7:4]),
    .ee_enable   (setup_latch_r[0]),
    .boot_enable (special_mode_flag_r),
    .area_guard  (eeprom_write_guard_r[3:0]),
    .setup_guard (eeprom_write_guard_r[4]),
    .sel         (dec_sel),
    .area_locked (dec_locked)
  );

  // Read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `PSCR_OFF_REMAP:   rdata_nxt = {24'h00_0000, memory_remap_r};
      `PSCR_OFF_STARTUP: rdata_nxt = {24'h00_0000, startup_settings_r};
      `PSCR_OFF_EXTRA:   rdata_nxt = {24'h00_0000, extra_settings_r};
      `PSCR_OFF_GUARD:   rdata_nxt = {24'h00_0000, eeprom_write_guard_r};
      `PSCR_OFF_STATUS:  rdata_nxt = {26'h000_0000, hstate_r, special_mode_flag_r,
                                      window_open, startup_done_r, remap_done_r};
      `PSCR_OFF_SETUP:   rdata_nxt = {24'h00_0000, setup_latch_r};
      `PSCR_OFF_DECODE:  rdata_nxt = {16'h0000, decode_addr_r};
      `PSCR_OFF_RESULT:  rdata_nxt = {28'h000_0000, dec_locked, dec_sel};
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end

  // APB handshake, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (rd_acc && !pready) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // Registered control outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_power_up   <= 1'b0;
      pump_clock_select    <= 1'b0;
      interrupt_edge_sense <= 1'b0;
      clock_watch_active   <= 1'b0;
      watchdog_rate_select <= 2'b00;
      fast_clock_output    <= 1'b0;
      halted               <= 1'b0;
      area_guard_bits      <= 4'hF;
      setup_byte_guard     <= 1'b1;
    end else begin
      converter_power_up   <= startup_settings_r[`PSCR_B_CONV];
      pump_clock_select    <= startup_settings_r[`PSCR_B_PSEL];
      interrupt_edge_sense <= startup_settings_r[`PSCR_B_IRQS];
      clock_watch_active   <= startup_settings_r[`PSCR_B_CWE] | startup_settings_r[`PSCR_B_FCW];
      watchdog_rate_select <= startup_settings_r[1:0];
      fast_clock_output    <= extra_settings_r[`PSCR_B_FCO];
      halted               <= (hstate_r != ST_RUN);
      area_guard_bits      <= eeprom_write_guard_r[3:0];
      setup_byte_guard     <= eeprom_write_guard_r[4];
    end
  end
endmodule // pscr_top
`default_nettype wire
